// file: inc/pac_params.svh
// constants of the process alarm comparator: offsets, reset values, timing
// assumes one 20 MHz clock; included by bare name from the rtl files
`ifndef PAC_PARAMS_SVH
`define PAC_PARAMS_SVH

// =====================================================================
// data widths
`define PAC_DATA_W        16
`define PAC_ADDR_W        5
`define PAC_NUM_ALARMS    8

// =====================================================================
// timing: the alarm-on delay counts in ticks of one millisecond
`define PAC_CLK_PERIOD_NS 50
`define PAC_TICK_NS       1000000
`define PAC_TICK_CYCLES   ((`PAC_TICK_NS) / (`PAC_CLK_PERIOD_NS))

// =====================================================================
// register offsets (word index on the plain register port)
`define PAC_OFS_THR_BASE  5'h00
`define PAC_OFS_HYST_PV   5'h08
`define PAC_OFS_HYST_RC   5'h09
`define PAC_OFS_DELAY     5'h0A
`define PAC_OFS_FLAGS     5'h0B
`define PAC_OFS_STATUS    5'h0C
`define PAC_OFS_MASK      5'h0D
`define PAC_OFS_PV        5'h0E
`define PAC_OFS_RATE      5'h0F
`define PAC_OFS_SPAN      5'h10
`define PAC_OFS_ZERO      5'h11

// =====================================================================
// threshold slot within a group of four, and group base
`define PAC_SLOT_UU       2'h0
`define PAC_SLOT_U        2'h1
`define PAC_SLOT_B        2'h2
`define PAC_SLOT_BB       2'h3
`define PAC_GRP_RATE      4

// =====================================================================
// reset values
`define PAC_RST_THR_UP    16'h7D00
`define PAC_RST_THR_LO    16'h8300
`define PAC_RST_HYST      16'h0000
`define PAC_RST_DELAY     16'h0000
`define PAC_RST_MASK      8'h00
`define PAC_RST_SPAN      16'h7D00
`define PAC_RST_ZERO      16'h0000

`endif

// file: inc/pac_pkg.sv
// types of the process alarm comparator
// assumes pac_params.svh is included before this package is compiled
`include "pac_params.svh"

package pac_pkg;

  // =====================================================================
  // register port request, one cycle wide
  typedef struct packed {
    logic [`PAC_ADDR_W-1:0] addr;
    logic [`PAC_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } pac_req_s;

  // =====================================================================
  // state of one alarm cell
  typedef struct packed {
    logic                   flag;
    logic                   armed;
    logic [`PAC_DATA_W-1:0] cnt;
  } pac_cell_s;

  // =====================================================================
  // state of the comparator top
  typedef struct packed {
    logic [`PAC_NUM_ALARMS-1:0][`PAC_DATA_W-1:0] thr;
    logic [1:0][`PAC_DATA_W-1:0]                 hyst;
    logic [`PAC_DATA_W-1:0]                      dly;
    logic [`PAC_DATA_W-1:0]                      span;
    logic [`PAC_DATA_W-1:0]                      zero;
    logic [`PAC_DATA_W-1:0]                      pv;
    logic [`PAC_DATA_W-1:0]                      rate;
    logic [`PAC_NUM_ALARMS-1:0]                  mask;
    logic [`PAC_NUM_ALARMS-1:0]                  status;
    logic [`PAC_NUM_ALARMS-1:0]                  flags_q;
    logic [`PAC_DATA_W-1:0]                      rdata;
    logic [`PAC_DATA_W-1:0]                      tick_cnt;
    logic                                        tick;
  } pac_state_s;

endpackage

// file: rtl/pac_alarm_cell.sv
// one alarm comparator with hysteresis release and alarm-on delay
// assumes value, threshold and hysteresis are stable flops of the same clock
`timescale 1ns/10ps
`include "pac_params.svh"

module pac_alarm_cell #(
  parameter int W = `PAC_DATA_W
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         tick_i,
  input  wire logic         upper_i,
  input  wire logic [W-1:0] value_i,
  input  wire logic [W-1:0] thr_i,
  input  wire logic [W-1:0] hyst_i,
  input  wire logic [W-1:0] delay_i,
  output logic              flag_o
);

  pac_pkg::pac_cell_s st_ff;
  pac_pkg::pac_cell_s nxt_st;
  logic signed [W+1:0] v_x;
  logic signed [W+1:0] t_x;
  logic signed [W+1:0] h_x;
  logic                trip;
  logic                release_c;

  // =====================================================================
  // comparisons, two guard bits so threshold +/- hysteresis never wraps
  always_comb begin
    v_x       = {{2{value_i[W-1]}}, value_i};
    t_x       = {{2{thr_i[W-1]}}, thr_i};
    h_x       = {2'b00, hyst_i};
    // only own input against own threshold, no look at other levels
    trip      = upper_i ? (v_x > t_x) : (v_x < t_x);
    release_c = upper_i ? (v_x < (t_x - h_x)) : (v_x > (t_x + h_x));
  end

  // =====================================================================
  // flag and delay counter; release uses the live threshold, so a raised
  // or lowered set value simply moves the release point
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.flag) begin
      if (release_c) begin
        nxt_st.flag = 1'b0;
      end
    end else if (release_c) begin
      // fell back before the delay ran out: never shows
      nxt_st.armed = 1'b0;
      nxt_st.cnt   = '0;
    end else if (trip || st_ff.armed) begin
      nxt_st.armed = 1'b1;
      if (st_ff.cnt >= delay_i) begin
        nxt_st.flag  = 1'b1;
        nxt_st.armed = 1'b0;
        nxt_st.cnt   = '0;
      end else if (tick_i) begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flag_o = st_ff.flag;

  // =====================================================================
  // checks
  a_upper_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ($rose(flag_o) && $past(upper_i))
      |-> $past(!release_c && ((v_x > t_x) || st_ff.armed)))
    else $error("upper flag rose without value above threshold");

  a_lower_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ($rose(flag_o) && !$past(upper_i))
      |-> $past(!release_c && ((v_x < t_x) || st_ff.armed)))
    else $error("lower flag rose without value below threshold");

  a_upper_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (flag_o && upper_i && !(v_x < (t_x - h_x))) |=> flag_o)
    else $error("upper flag dropped inside hysteresis band");

  a_lower_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (flag_o && !upper_i && !(v_x > (t_x + h_x))) |=> flag_o)
    else $error("lower flag dropped inside hysteresis band");

  a_flag_release: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (flag_o && release_c) |=> !flag_o)
    else $error("flag not released past hysteresis");

  a_no_early: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!flag_o && (release_c || (!trip && !st_ff.armed))) |=> !flag_o)
    else $error("flag set without pending alarm condition");

  a_delay_met: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(flag_o) |-> $past(st_ff.cnt >= delay_i))
    else $error("flag set before on delay elapsed");

endmodule // pac_alarm_cell

// file: rtl/pac_top.sv
// process alarm comparator: scaling, rate of change, eight alarm cells,
// register port and interrupt
// assumes raw samples come from the measurement path on the same clock and
// the register master issues one-cycle strobes, never wr and rd together
`timescale 1ns/10ps
`include "pac_params.svh"

module pac_top #(
  parameter int unsigned TICK_CYCLES = `PAC_TICK_CYCLES,
  parameter int          W           = `PAC_DATA_W,
  parameter int          N           = `PAC_NUM_ALARMS
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [W-1:0]     raw_i,
  input  wire logic             sample_valid_i,
  input  wire pac_pkg::pac_req_s req_i,
  output logic [W-1:0]          rdata_o,
  output logic [N-1:0]          alarm_o,
  output logic                  irq_o
);

  pac_pkg::pac_state_s st_ff;
  pac_pkg::pac_state_s nxt_st;
  logic signed [W:0]     span_diff;
  logic signed [2*W+1:0] prod;
  logic signed [W+1:0]   scaled_x;
  logic [W-1:0]          scaled;
  logic signed [W+1:0]   rate_x;
  logic [W-1:0]          rate_c;
  logic [N-1:0]          flags;
  logic [N-1:0]          events;
  logic [N-1:0]          w1c;
  logic                  is_thr;

  // =====================================================================
  // saturate a guarded value back to the signed data width
  function automatic logic [W-1:0] sat(input logic signed [W+1:0] x);
    logic signed [W+1:0] hi;
    logic signed [W+1:0] lo;
    hi = (W+2)'((1 << (W-1)) - 1);
    lo = -hi - 1;
    if (x > hi) begin
      sat = {1'b0, {(W-1){1'b1}}};
    end else if (x < lo) begin
      sat = {1'b1, {(W-1){1'b0}}};
    end else begin
      sat = x[W-1:0];
    end
  endfunction

  // =====================================================================
  // scaling: raw is an unsigned fraction of full range; zero maps to raw 0
  // and span to full scale. span below zero gives a negative span_diff and the
  // same arithmetic inverts the slope, so alarms always see the scaled value
  always_comb begin
    span_diff = {st_ff.span[W-1], st_ff.span} - {st_ff.zero[W-1], st_ff.zero};
    prod      = (2*W+2)'(span_diff * $signed({1'b0, raw_i}));
    scaled_x  = {{2{st_ff.zero[W-1]}}, st_ff.zero} + prod[2*W+1:W];
    scaled    = sat(scaled_x);
    // rate of change is the step between consecutive scaled samples
    rate_x    = {{2{scaled[W-1]}}, scaled} - {{2{st_ff.pv[W-1]}}, st_ff.pv};
    rate_c    = sat(rate_x);
  end

  // =====================================================================
  // alarm cells: 0..3 watch the process value, 4..7 the rate of change;
  // slot order within a group is upper_upper, upper, bottom, bottom_bottom
  for (genvar i = 0; i < N; i++) begin : g_cell
    localparam int GRP = i / `PAC_GRP_RATE;
    localparam int SLOT = i % `PAC_GRP_RATE;
    pac_alarm_cell #(
      .W(W)
    ) u_cell (
      .clk_i   (clk_i),
      .resetn_i(resetn_i),
      .tick_i  (st_ff.tick),
      .upper_i (SLOT < 2),
      .value_i ((GRP == 0) ? st_ff.pv : st_ff.rate),
      .thr_i   (st_ff.thr[i]),
      .hyst_i  (st_ff.hyst[GRP]),
      .delay_i (st_ff.dly),
      .flag_o  (flags[i])
    );
  end

  // =====================================================================
  // register port decode and next state
  always_comb begin
    nxt_st = st_ff;
    is_thr = (req_i.addr < 5'(N));
    w1c    = '0;
    events = flags & ~st_ff.flags_q;

    // one millisecond tick for the alarm-on delay
    nxt_st.tick = 1'b0;
    if (st_ff.tick_cnt == 16'(TICK_CYCLES - 1)) begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick     = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
    end

    // new sample: latch scaled value and its step
    if (sample_valid_i) begin
      nxt_st.pv   = scaled;
      nxt_st.rate = rate_c;
    end

    // writes; thresholds take any value in any order
    if (req_i.wr) begin
      if (is_thr) begin
        nxt_st.thr[req_i.addr[2:0]] = req_i.wdata;
      end else begin
        unique case (req_i.addr)
          `PAC_OFS_HYST_PV: nxt_st.hyst[0] = req_i.wdata;
          `PAC_OFS_HYST_RC: nxt_st.hyst[1] = req_i.wdata;
          `PAC_OFS_DELAY:   nxt_st.dly     = req_i.wdata;
          `PAC_OFS_STATUS:  w1c            = req_i.wdata[N-1:0];
          `PAC_OFS_MASK:    nxt_st.mask    = req_i.wdata[N-1:0];
          `PAC_OFS_SPAN:    nxt_st.span    = req_i.wdata;
          `PAC_OFS_ZERO:    nxt_st.zero    = req_i.wdata;
          default:          nxt_st.mask    = st_ff.mask;
        endcase
      end
    end

    // sticky events; a new edge in the clearing cycle survives
    nxt_st.flags_q = flags;
    nxt_st.status  = (st_ff.status & ~w1c) | events;

    // read data stand for one cycle only
    nxt_st.rdata = '0;
    if (req_i.rd) begin
      if (is_thr) begin
        nxt_st.rdata = st_ff.thr[req_i.addr[2:0]];
      end else begin
        unique case (req_i.addr)
          `PAC_OFS_HYST_PV: nxt_st.rdata = st_ff.hyst[0];
          `PAC_OFS_HYST_RC: nxt_st.rdata = st_ff.hyst[1];
          `PAC_OFS_DELAY:   nxt_st.rdata = st_ff.dly;
          `PAC_OFS_FLAGS:   nxt_st.rdata = W'(flags);
          `PAC_OFS_STATUS:  nxt_st.rdata = W'(st_ff.status);
          `PAC_OFS_MASK:    nxt_st.rdata = W'(st_ff.mask);
          `PAC_OFS_PV:      nxt_st.rdata = st_ff.pv;
          `PAC_OFS_RATE:    nxt_st.rdata = st_ff.rate;
          `PAC_OFS_SPAN:    nxt_st.rdata = st_ff.span;
          `PAC_OFS_ZERO:    nxt_st.rdata = st_ff.zero;
          default:          nxt_st.rdata = '0;
        endcase
      end
    end
  end

  // =====================================================================
  // state register with reset values
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_ff          <= '0;
      st_ff.hyst     <= {2{`PAC_RST_HYST}};
      st_ff.dly      <= `PAC_RST_DELAY;
      st_ff.mask     <= `PAC_RST_MASK;
      st_ff.span     <= `PAC_RST_SPAN;
      st_ff.zero     <= `PAC_RST_ZERO;
      // thresholds open so nothing trips out of reset
      for (int k = 0; k < N; k++) begin
        st_ff.thr[k] <= ((k % `PAC_GRP_RATE) < 2) ? `PAC_RST_THR_UP : `PAC_RST_THR_LO;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  // =====================================================================
  // outputs
  assign rdata_o = st_ff.rdata;
  assign alarm_o = flags;
  // level output, drops as soon as status is cleared or masked
  assign irq_o   = |(st_ff.status & st_ff.mask);

  // =====================================================================
  // checks
  a_rate_step: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sample_valid_i |=> (st_ff.rate == sat({{2{st_ff.pv[W-1]}}, st_ff.pv}
                                         - {{2{$past(st_ff.pv[W-1])}}, $past(st_ff.pv)})))
    else $error("rate value is not the step between samples");

  a_scaled_pv: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sample_valid_i |=> (st_ff.pv == $past(scaled)))
    else $error("process value not taken from scaled result");

  a_flag_indep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(flags[1]) |-> $past(($signed(st_ff.pv) > $signed(st_ff.thr[1]))
                              || g_cell[1].u_cell.st_ff.armed))
    else $error("upper flag rose without own comparison");

  a_status_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(flags[0]) |=> st_ff.status[0])
    else $error("alarm edge lost from status");

  a_irq_level: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!req_i.wr && ((st_ff.status & st_ff.mask) != '0)) |=> irq_o)
    else $error("interrupt dropped while masked status stands");

  a_read_once: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !$past(req_i.rd) |-> (rdata_o == '0))
    else $error("read data outside its cycle");

  // =====================================================================
  // register port checks: every write but span and zero lands, reads of thresholds, flags, status, value,
  // rate and unmapped words return their word, thresholds keep without a write and value and rate without a sample
  a_thr_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.wr && is_thr) |=> (st_ff.thr[$past(req_i.addr[2:0])] == $past(req_i.wdata)))
    else $error("threshold write lost");

  a_thr_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !req_i.wr |=> $stable(st_ff.thr))
    else $error("threshold moved without a write");

  a_hyst_pv: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.wr && (req_i.addr == `PAC_OFS_HYST_PV)) |=> (st_ff.hyst[0] == $past(req_i.wdata)))
    else $error("value hysteresis write lost");

  a_hyst_rate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.wr && (req_i.addr == `PAC_OFS_HYST_RC)) |=> (st_ff.hyst[1] == $past(req_i.wdata)))
    else $error("rate hysteresis write lost");

  a_delay_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.wr && (req_i.addr == `PAC_OFS_DELAY)) |=> (st_ff.dly == $past(req_i.wdata)))
    else $error("on delay write lost");

  a_mask_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.wr && (req_i.addr == `PAC_OFS_MASK)) |=> (st_ff.mask == $past(req_i.wdata[N-1:0])))
    else $error("mask write lost");

  a_status_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.wr && (req_i.addr == `PAC_OFS_STATUS) && (events == '0))
      |=> ((st_ff.status & $past(req_i.wdata[N-1:0])) == '0))
    else $error("status bits not cleared by writing ones");

  a_status_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !req_i.wr |=> ((st_ff.status & $past(st_ff.status)) == $past(st_ff.status)))
    else $error("status bit lost without a clear");

  a_pv_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !sample_valid_i |=> ($stable(st_ff.pv) && $stable(st_ff.rate)))
    else $error("value or rate moved without a sample");

  a_scale_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (sample_valid_i && (raw_i == '0)) |=> (st_ff.pv == $past(st_ff.zero)))
    else $error("bottom of raw range not scaled to zero setting");

  a_read_thr: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.rd && is_thr) |=> (rdata_o == $past(st_ff.thr[req_i.addr[2:0]])))
    else $error("threshold read returned wrong word");

  a_read_flags: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.rd && (req_i.addr == `PAC_OFS_FLAGS)) |=> (rdata_o == W'($past(flags))))
    else $error("flag read returned wrong word");

  a_read_status: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.rd && (req_i.addr == `PAC_OFS_STATUS)) |=> (rdata_o == W'($past(st_ff.status))))
    else $error("status read returned wrong word");

  a_read_pv: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.rd && (req_i.addr == `PAC_OFS_PV)) |=> (rdata_o == $past(st_ff.pv)))
    else $error("value read returned wrong word");

  a_read_rate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.rd && (req_i.addr == `PAC_OFS_RATE)) |=> (rdata_o == $past(st_ff.rate)))
    else $error("rate read returned wrong word");

  a_read_unmapped: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i.rd && (req_i.addr > `PAC_OFS_ZERO)) |=> (rdata_o == '0))
    else $error("unmapped read returned data");

  // =====================================================================
  // delay tick: a single cycle pulse at the wrap of its counter
  a_tick_phase: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st_ff.tick |-> (st_ff.tick_cnt == '0))
    else $error("delay tick off its counter wrap");

  a_tick_single: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st_ff.tick && (TICK_CYCLES > 1)) |=> !st_ff.tick)
    else $error("delay tick longer than one cycle");

  // =====================================================================
  // per-alarm checks; a status bit only rises on its own alarm edge, and a
  // masked edge reaches the interrupt pin one cycle later
  for (genvar j = 0; j < N; j++) begin : g_chk
    a_status_cause: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(st_ff.status[j]) |-> $past(flags[j] && !st_ff.flags_q[j]))
      else $error("status bit set without alarm edge");

    a_edge_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ($rose(flags[j]) && nxt_st.mask[j]) |=> irq_o)
      else $error("masked alarm edge raised no interrupt");
  end

endmodule // pac_top

// file: verification/pac_cpu_model.sv
// controller cpu model: issues one-cycle register strobes, reads answers
// assumes the comparator answers a read in the cycle after the strobe
`timescale 1ns/10ps
`include "pac_params.svh"

module pac_cpu_model (
  input  wire logic                   clk_i,
  input  wire logic [`PAC_DATA_W-1:0] rdata_i,
  output pac_pkg::pac_req_s           req_o
);
  // =====================================================================
  // access tasks
  initial req_o = '0;

  // write: one strobe cycle; address and data scrambled once released so
  // nothing can lean on a stale bus value
  task automatic write_reg(input logic [`PAC_ADDR_W-1:0] a, input logic [`PAC_DATA_W-1:0] d);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  // read: data stand for one cycle only, so they are taken mid-cycle
  task automatic read_reg(input logic [`PAC_ADDR_W-1:0] a, output logic [`PAC_DATA_W-1:0] d);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: 16'h5A5A, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req_o <= '{addr: ~a, wdata: 16'hA5A5, wr: 1'b0, rd: 1'b0};
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule // pac_cpu_model

// file: verification/process_alarm_comparator_tb_top.sv
// testbench of the process alarm comparator: register, sample and alarm checks
// assumes the cpu model drives the register port; short 4-cycle delay tick
`timescale 1ns/10ps
`include "pac_params.svh"

module process_alarm_comparator_tb_top;
  logic              clk_i;
  logic              resetn_i;
  logic              sample_valid_i;
  logic              irq_o;
  logic [15:0]       raw_i;
  logic [15:0]       rdata_o;
  logic [7:0]        alarm_o;
  pac_pkg::pac_req_s req_i;
  int                failures = 0;
  int                num_checks = 0;
  int                cycles = 0;

  // =====================================================================
  // clock, design and cpu model
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  pac_top #(.TICK_CYCLES(4)) u_pac_top (.clk_i(clk_i), .resetn_i(resetn_i), .raw_i(raw_i),
    .sample_valid_i(sample_valid_i), .req_i(req_i), .rdata_o(rdata_o), .alarm_o(alarm_o),
    .irq_o(irq_o));

  pac_cpu_model u_pac_cpu_model (.clk_i(clk_i), .rdata_i(rdata_o), .req_o(req_i));

  // =====================================================================
  // tasks
  task automatic complete_run();
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic miss(input string m);
    failures++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    u_pac_cpu_model.write_reg(a, d);
  endtask

  task automatic chk_reg(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_pac_cpu_model.read_reg(a, d);
    num_checks++;
    if (d !== e) miss($sformatf("reg %h got %h exp %h", a, d, e));
  endtask

  // flags compared under a mask at the next falling edge
  task automatic chk_alarm(input logic [7:0] m, input logic [7:0] e);
    @(negedge clk_i);
    num_checks++;
    if ((alarm_o & m) !== e) miss($sformatf("alarms %h exp %h", alarm_o & m, e));
  endtask

  task automatic chk_irq(input logic e);
    @(negedge clk_i);
    num_checks++;
    if (irq_o !== e) miss("interrupt level");
  endtask

  // one sample pulse, then time for scaling, compare and status to settle
  task automatic sample(input logic [15:0] r);
    @(posedge clk_i);
    raw_i <= r;
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    raw_i <= ~r;
    repeat (4) @(posedge clk_i);
  endtask

  // =====================================================================
  // hang guard: whole run is well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miss("timeout");
      complete_run();
    end
  end

  // =====================================================================
  // main sequence
  initial begin
    resetn_i = 1'b0;
    raw_i = 16'h0000;
    sample_valid_i = 1'b0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    // reset state and register map
    chk_alarm(8'hFF, 8'h00);
    chk_irq(1'b0);
    for (int i = 0; i < 8; i++) begin
      chk_reg(i[4:0], (i % 4 < 2) ? 16'h7D00 : 16'h8300);
    end
    chk_reg(`PAC_OFS_MASK, 16'h0000);
    chk_reg(`PAC_OFS_SPAN, 16'h7D00);
    chk_reg(5'h1F, 16'h0000);
    // levels out of order: lower trip above upper trip
    wr(5'h00, 16'h2000);
    wr(5'h01, 16'h1000);
    wr(5'h02, 16'h3000);
    wr(5'h03, 16'h0800);
    wr(5'h04, 16'h1000);
    wr(5'h07, 16'hF000);
    chk_reg(5'h07, 16'hF000);
    // inverted scaling: raw above the threshold, scaled value below it
    wr(`PAC_OFS_SPAN, 16'h0000);
    wr(`PAC_OFS_ZERO, 16'h0FA0);
    sample(16'h4000);
    chk_reg(`PAC_OFS_PV, 16'h0BB8);
    chk_alarm(8'hFF, 8'h04);
    wr(`PAC_OFS_SPAN, 16'h7D00);
    wr(`PAC_OFS_ZERO, 16'h0000);
    // value and rate trips in both directions
    sample(16'h4000);
    wr(`PAC_OFS_PV, 16'h1234);
    chk_reg(`PAC_OFS_PV, 16'h1F40);
    chk_alarm(8'hFF, 8'h16);
    sample(16'h8000);
    chk_alarm(8'hFF, 8'h13);
    sample(16'h1000);
    chk_alarm(8'hFF, 8'h8C);
    chk_reg(`PAC_OFS_FLAGS, 16'h008C);
    chk_reg(`PAC_OFS_RATE, 16'hC950);
    // sticky status, mask and interrupt level
    wr(`PAC_OFS_STATUS, 16'h00FF);
    wr(`PAC_OFS_MASK, 16'h00FF);
    chk_reg(`PAC_OFS_STATUS, 16'h0000);
    chk_irq(1'b0);
    sample(16'h4000);
    chk_reg(`PAC_OFS_STATUS, 16'h0012);
    chk_irq(1'b1);
    wr(`PAC_OFS_MASK, 16'h0001);
    chk_irq(1'b0);
    wr(`PAC_OFS_MASK, 16'h0002);
    chk_irq(1'b1);
    wr(`PAC_OFS_STATUS, 16'h0002);
    chk_irq(1'b0);
    chk_reg(`PAC_OFS_STATUS, 16'h0010);
    // moved thresholds while flags are on, with hysteresis
    // rate hysteresis too: bit 7 is held inside its band on the last step
    wr(`PAC_OFS_HYST_PV, 16'h0100);
    wr(`PAC_OFS_HYST_RC, 16'h0100);
    chk_reg(`PAC_OFS_HYST_RC, 16'h0100);
    wr(5'h01, 16'h2000);
    wr(5'h02, 16'h1F00);
    chk_alarm(8'hFF, 8'h16);
    sample(16'h8000);
    chk_alarm(8'hFF, 8'h13);
    sample(16'h4000);
    chk_alarm(8'hFF, 8'h83);
    sample(16'h2000);
    chk_alarm(8'hFF, 8'h84);
    // on-delay of 3 ticks: a one-cycle excursion never shows
    wr(`PAC_OFS_DELAY, 16'h0003);
    chk_reg(`PAC_OFS_DELAY, 16'h0003);
    @(posedge clk_i);
    raw_i <= 16'h8000;
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    raw_i <= 16'h2000;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    repeat (30) chk_alarm(8'h01, 8'h00);
    sample(16'h8000);
    chk_alarm(8'h01, 8'h00);
    repeat (20) @(posedge clk_i);
    chk_alarm(8'h01, 8'h01);
    // bottom of the raw range lands on the zero setting
    sample(16'h0000);
    chk_reg(`PAC_OFS_PV, 16'h0000);
    complete_run();
  end
endmodule // process_alarm_comparator_tb_top
